/* File: rtl/ced_pkg.sv */
// constants for the comparator event and debounce block
package ced_pkg;
    // ==========================================================
    // bus and register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] CTRL_ADDR = 8'h97;
    localparam logic [7:0] SRC_ADDR = 8'h9a;
    localparam logic [7:0] IE_ADDR = 8'h9b;
    localparam logic [7:0] ISTAT_ADDR = 8'h9c;
    localparam logic [7:0] ICLR_ADDR = 8'h9d;
    localparam logic [7:0] IEN_ADDR = 8'h9e;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // ==========================================================
    // control, interrupt enable and source register fields
    localparam int SEL_HI = 7;
    localparam int SEL_LO = 6;
    localparam int LINK_BIT = 5;
    localparam int FLAG_BIT = 4;
    localparam int ON_BIT = 3;
    localparam int MODE_HI = 2;
    localparam int MODE_LO = 0;
    localparam int IE_BIT = 6;
    localparam int SRC_W = 2;
    // ==========================================================
    // interrupt mode codes
    localparam logic [2:0] MODE_LOW = 3'h0;
    localparam logic [2:0] MODE_RISE = 3'h1;
    localparam logic [2:0] MODE_DB_TOGGLE = 3'h2;
    localparam logic [2:0] MODE_DB_RISE = 3'h3;
    localparam logic [2:0] MODE_FALL = 3'h4;
    localparam logic [2:0] MODE_TOGGLE = 3'h5;
    localparam logic [2:0] MODE_DB_FALL = 3'h6;
    localparam logic [2:0] MODE_HIGH = 3'h7;
    // ==========================================================
    // sample source codes
    localparam logic [1:0] SRC_CLOCK = 2'h0;
    localparam logic [1:0] SRC_T0 = 2'h1;
    localparam logic [1:0] SRC_T1 = 2'h2;
    localparam logic [1:0] SRC_T2 = 2'h3;
    // ==========================================================
    // filter and debounce counts
    localparam int FILTER_CNT = 4;
    localparam int DBN_OVF = 2;
    localparam int CNT_W = 3;
    // ==========================================================
    // event status bits
    localparam int EVT_W = 2;
    localparam int EVT_FLAG = 0;
    localparam int EVT_DROP = 1;
    // ==========================================================
    // debounce states
    typedef enum logic [1:0] {
        CED_IDLE = 2'b01,
        CED_WAIT = 2'b10
    } ced_state_e;
endpackage

/* File: rtl/ced_sync.sv */
// three-stage synchroniser with agreement check for the comparator output
`timescale 1ns/100ps
`default_nettype none
module ced_sync (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // raw level and clean level
    input wire logic async_i,
    output logic level_o
);
    // ==========================================================
    // chain; stage one feeds stage two only
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // ==========================================================
    // a change counts once stages two and three agree
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            level_o <= 1'b0;
        end else if (s2_q == s3_q) begin
            level_o <= s3_q;
        end
    end
endmodule // ced_sync
`default_nettype wire

/* File: rtl/ced_top.sv */
// comparator a event detection, debouncing and control/status register
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module ced_top (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [ced_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ced_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [ced_pkg::DATA_W-1:0] rdata_o,
    // comparator and timers
    input wire logic cmp_out_i,
    input wire logic timer0_ovf_i,
    input wire logic timer1_ovf_i,
    input wire logic timer2_ovf_i,
    // analog front end control
    output logic [1:0] positive_input_select_a_o,
    output logic input_link_a_o,
    output logic comparator_on_a_o,
    output logic digital_input_disable_o,
    // interrupts
    output logic cmp_irq_o,
    output logic irq_o
);
    // ==========================================================
    // register state
    logic [1:0] sel_q;
    logic link_q;
    logic flag_q;
    logic on_q;
    logic [2:0] mode_q;
    logic [ced_pkg::SRC_W-1:0] src_q;
    logic [ced_pkg::DATA_W-1:0] ie_q;
    logic [ced_pkg::EVT_W-1:0] evt_q;
    logic [ced_pkg::EVT_W-1:0] ien_q;
    logic [ced_pkg::DATA_W-1:0] rdata_q;
    logic cmp_irq_q;
    logic irq_q;
    // filter and debounce state
    logic lvl_q;
    logic [ced_pkg::CNT_W-1:0] fcnt_q;
    ced_pkg::ced_state_e st_q;
    logic exp_q;
    logic t1cnt_q;
    // combinational
    logic cmp_sync;
    logic cmp_int;
    logic tick;
    logic edge_evt;
    logic hit;
    logic is_dbn;
    logic dbn_done;
    logic set_d;
    logic drop_d;
    logic ctrl_wr;
    logic [ced_pkg::CNT_W-1:0] need;
    // ==========================================================
    // comparator input crossing
    ced_sync u_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .async_i(cmp_out_i),
        .level_o(cmp_sync)
    );
    // ==========================================================
    // sampling and condition decode
    always_comb begin
        cmp_int = cmp_sync & on_q;
        ctrl_wr = wr_i && (addr_i == ced_pkg::CTRL_ADDR);
        if (src_q == ced_pkg::SRC_CLOCK) begin
            tick = 1'b1;
        end else if (src_q == ced_pkg::SRC_T0) begin
            tick = timer0_ovf_i;
        end else if (src_q == ced_pkg::SRC_T1) begin
            tick = timer1_ovf_i;
        end else begin
            tick = timer2_ovf_i;
        end
        // slow sources need a persistent change
        need = (src_q == ced_pkg::SRC_CLOCK) ? ced_pkg::CNT_W'(1)
                                             : ced_pkg::CNT_W'(ced_pkg::FILTER_CNT);
        edge_evt = on_q && tick && (cmp_int != lvl_q) && ((fcnt_q + 1'b1) >= need);
        is_dbn = 1'b0;
        hit = 1'b0;
        case (mode_q)
            ced_pkg::MODE_LOW: hit = tick && !lvl_q;
            ced_pkg::MODE_HIGH: hit = tick && lvl_q;
            ced_pkg::MODE_RISE: hit = edge_evt && cmp_int;
            ced_pkg::MODE_FALL: hit = edge_evt && !cmp_int;
            ced_pkg::MODE_TOGGLE: hit = edge_evt;
            ced_pkg::MODE_DB_RISE: begin
                is_dbn = 1'b1;
                hit = edge_evt && cmp_int;
            end
            ced_pkg::MODE_DB_FALL: begin
                is_dbn = 1'b1;
                hit = edge_evt && !cmp_int;
            end
            default: begin
                is_dbn = 1'b1;
                hit = edge_evt;
            end
        endcase
        // second timer 1 overflow ends the wait
        dbn_done = (st_q == ced_pkg::CED_WAIT) && timer1_ovf_i && t1cnt_q;
        set_d = 1'b0;
        drop_d = 1'b0;
        if (on_q) begin
            if (dbn_done) begin
                set_d = (cmp_int == exp_q);
                drop_d = (cmp_int != exp_q);
            end else if (!is_dbn && hit) begin
                set_d = 1'b1;
            end
        end
    end
    // ==========================================================
    // accepted level and persistence counter
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lvl_q <= 1'b0;
            fcnt_q <= '0;
        end else if (!on_q) begin
            lvl_q <= 1'b0;
            fcnt_q <= '0;
        end else if (tick) begin
            if (edge_evt) begin
                lvl_q <= cmp_int;
                fcnt_q <= '0;
            end else if (cmp_int != lvl_q) begin
                fcnt_q <= fcnt_q + 1'b1;
            end else begin
                fcnt_q <= '0;
            end
        end
    end
    // ==========================================================
    // debounce wait; timer 1 free runs, so two overflows give at least one period
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q <= ced_pkg::CED_IDLE;
            exp_q <= 1'b0;
            t1cnt_q <= 1'b0;
        end else if (!on_q) begin
            st_q <= ced_pkg::CED_IDLE;
            t1cnt_q <= 1'b0;
        end else begin
            case (st_q)
                ced_pkg::CED_IDLE: begin
                    if (is_dbn && hit) begin
                        st_q <= ced_pkg::CED_WAIT;
                        exp_q <= cmp_int;
                        t1cnt_q <= 1'b0;
                    end
                end
                ced_pkg::CED_WAIT: begin
                    if (dbn_done) begin
                        st_q <= ced_pkg::CED_IDLE;
                        t1cnt_q <= 1'b0;
                    end else if (timer1_ovf_i) begin
                        t1cnt_q <= 1'b1;
                    end
                end
                default: begin
                    st_q <= ced_pkg::CED_IDLE;
                end
            endcase
        end
    end
    // ==========================================================
    // control register
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sel_q <= ced_pkg::CTRL_RST[ced_pkg::SEL_HI:ced_pkg::SEL_LO];
            link_q <= ced_pkg::CTRL_RST[ced_pkg::LINK_BIT];
            on_q <= ced_pkg::CTRL_RST[ced_pkg::ON_BIT];
            mode_q <= ced_pkg::CTRL_RST[ced_pkg::MODE_HI:ced_pkg::MODE_LO];
        end else if (ctrl_wr) begin
            sel_q <= wdata_i[ced_pkg::SEL_HI:ced_pkg::SEL_LO];
            link_q <= wdata_i[ced_pkg::LINK_BIT];
            on_q <= wdata_i[ced_pkg::ON_BIT];
            mode_q <= wdata_i[ced_pkg::MODE_HI:ced_pkg::MODE_LO];
        end
    end
    // flag: hardware set wins over a software write of zero
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flag_q <= ced_pkg::CTRL_RST[ced_pkg::FLAG_BIT];
        end else if (set_d) begin
            flag_q <= 1'b1;
        end else if (ctrl_wr) begin
            flag_q <= wdata_i[ced_pkg::FLAG_BIT];
        end
    end
    // ==========================================================
    // source select and cpu interrupt enable
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            src_q <= ced_pkg::SRC_CLOCK;
            ie_q <= ced_pkg::READ_ZERO;
        end else if (wr_i && (addr_i == ced_pkg::SRC_ADDR)) begin
            src_q <= wdata_i[ced_pkg::SRC_W-1:0];
        end else if (wr_i && (addr_i == ced_pkg::IE_ADDR)) begin
            ie_q <= wdata_i;
        end
    end
    // ==========================================================
    // event status, clear and enable
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            evt_q <= '0;
        end else begin
            for (int i = 0; i < ced_pkg::EVT_W; i++) begin
                if ((i == ced_pkg::EVT_FLAG && set_d) || (i == ced_pkg::EVT_DROP && drop_d)) begin
                    evt_q[i] <= 1'b1;
                end else if (wr_i && (addr_i == ced_pkg::ICLR_ADDR) && wdata_i[i]) begin
                    evt_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ien_q <= '0;
        end else if (wr_i && (addr_i == ced_pkg::IEN_ADDR)) begin
            ien_q <= wdata_i[ced_pkg::EVT_W-1:0];
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cmp_irq_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            cmp_irq_q <= flag_q & ie_q[ced_pkg::IE_BIT];
            irq_q <= |(evt_q & ien_q);
        end
    end
    // ==========================================================
    // read port, data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_q <= ced_pkg::READ_ZERO;
        end else if (!rd_i) begin
            rdata_q <= ced_pkg::READ_ZERO;
        end else if (addr_i == ced_pkg::CTRL_ADDR) begin
            rdata_q <= {sel_q, link_q, flag_q, on_q, mode_q};
        end else if (addr_i == ced_pkg::SRC_ADDR) begin
            rdata_q <= {{(ced_pkg::DATA_W-ced_pkg::SRC_W){1'b0}}, src_q};
        end else if (addr_i == ced_pkg::IE_ADDR) begin
            rdata_q <= ie_q;
        end else if (addr_i == ced_pkg::ISTAT_ADDR) begin
            rdata_q <= {{(ced_pkg::DATA_W-ced_pkg::EVT_W){1'b0}}, evt_q};
        end else if (addr_i == ced_pkg::IEN_ADDR) begin
            rdata_q <= {{(ced_pkg::DATA_W-ced_pkg::EVT_W){1'b0}}, ien_q};
        end else begin
            rdata_q <= ced_pkg::READ_ZERO;
        end
    end
    // ==========================================================
    // outputs; software must drop the link before changing select
    assign rdata_o = rdata_q;
    assign positive_input_select_a_o = sel_q;
    assign input_link_a_o = link_q;
    assign comparator_on_a_o = on_q;
    assign digital_input_disable_o = on_q;
    assign cmp_irq_o = cmp_irq_q;
    assign irq_o = irq_q;
    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    sequence s_second_ovf;
        st_q == ced_pkg::CED_WAIT && timer1_ovf_i && t1cnt_q;
    endsequence
    sequence s_arm;
        st_q == ced_pkg::CED_IDLE && on_q && is_dbn && hit;
    endsequence
    flag_sw_clear_a: assert property ($fell(flag_q) |->
        $past(ctrl_wr && !wdata_i[ced_pkg::FLAG_BIT]))
        else $error("flag cleared without software write");
    flag_needs_on_a: assert property ($rose(flag_q) && !$past(ctrl_wr) |->
        $past(on_q))
        else $error("flag set while comparator off");
    off_forces_low_a: assert property (!on_q |=> !lvl_q &&
        st_q == ced_pkg::CED_IDLE && (flag_q == $past(flag_q) || $past(ctrl_wr)))
        else $error("disabled comparator still raised an event");
    irq_gate_a: assert property (cmp_irq_o |->
        $past(flag_q) && $past(ie_q[ced_pkg::IE_BIT]))
        else $error("cpu request without enable bit");
    link_follows_a: assert property (ctrl_wr |=>
        input_link_a_o == $past(wdata_i[ced_pkg::LINK_BIT]))
        else $error("input link does not follow write");
    buf_disable_a: assert property (ctrl_wr |=>
        digital_input_disable_o == $past(wdata_i[ced_pkg::ON_BIT]))
        else $error("buffer disable does not follow enable");
    dbn_two_ovf_a: assert property (set_d && is_dbn |-> s_second_ovf)
        else $error("debounced flag before second timer overflow");
    dbn_arm_wait_a: assert property (s_arm ##1 on_q |-> st_q == ced_pkg::CED_WAIT)
        else $error("debounce did not enter wait");
    dbn_match_a: assert property (s_second_ovf and (on_q && cmp_int == exp_q) |=>
        flag_q)
        else $error("matching resample did not set flag");
    filter_four_a: assert property (edge_evt && src_q != ced_pkg::SRC_CLOCK |->
        fcnt_q == ced_pkg::CNT_W'(ced_pkg::FILTER_CNT - 1))
        else $error("edge accepted before four samples");
    clock_sample_a: assert property (on_q && src_q == ced_pkg::SRC_CLOCK &&
        cmp_int != lvl_q |=> lvl_q == $past(cmp_int))
        else $error("clock source missed a sample");
endmodule // ced_top
`default_nettype wire

/* File: sim/ced_partner.sv */
// far-side model: analog comparator output and three free-running timer overflows
`timescale 1ns/100ps
`default_nettype none
module ced_partner #(
    parameter int P0 = 16,
    parameter int P1 = 20,
    parameter int P2 = 24
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // commanded comparator level
    input wire logic level_i,
    // comparator and timers
    output logic cmp_out_o,
    output logic [2:0] ovf_o
);
    // ==========================================================
    // comparator output
    // moves off the clock edge, as a real asynchronous level would
    initial begin
        cmp_out_o = 1'b0;
        forever begin
            @(level_i);
            cmp_out_o <= #7 level_i;
        end
    end
    // ==========================================================
    // timer overflows
    int cnt_q [3];
    function automatic int per(input int k);
        return (k == 0) ? P0 : ((k == 1) ? P1 : P2);
    endfunction
    // timer 1 never stops, so every debounce wait can complete
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        for (int k = 0; k < 3; k++) begin
            if (sys_rst_i) begin
                cnt_q[k] <= 0;
                ovf_o[k] <= 1'b0;
            end else begin
                cnt_q[k] <= (cnt_q[k] == per(k) - 1) ? 0 : cnt_q[k] + 1;
                ovf_o[k] <= (cnt_q[k] == per(k) - 1);
            end
        end
    end
endmodule // ced_partner
`default_nettype wire

/* File: sim/ced_top_tb_top.sv */
// self-checking testbench for the comparator event block
`timescale 1ns/100ps
`default_nettype none
module ced_top_tb_top;
    // ==========================================================
    // signals
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic lvl = 1'b0;
    logic cmp;
    logic [2:0] ovf;
    logic [1:0] sel;
    logic link, on, did, cmp_irq, irq;
    logic [7:0] d;
    logic [5:0] e;
    int fails = 0;
    int tests_run = 0;
    // mode, start level, end level, expected flag
    logic [5:0] tbl [12] = '{6'b000001, 6'b001011, 6'b010101, 6'b011011, 6'b100101,
        6'b101011, 6'b110101, 6'b111111, 6'b001100, 6'b100010, 6'b011100, 6'b110010};
    // ==========================================================
    // design and far side
    ced_top i_dut (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cmp_out_i(cmp), .timer0_ovf_i(ovf[0]),
        .timer1_ovf_i(ovf[1]), .timer2_ovf_i(ovf[2]), .positive_input_select_a_o(sel),
        .input_link_a_o(link), .comparator_on_a_o(on), .digital_input_disable_o(did),
        .cmp_irq_o(cmp_irq), .irq_o(irq)
    );
    ced_partner i_far (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .level_i(lvl),
        .cmp_out_o(cmp), .ovf_o(ovf)
    );
    initial begin
        forever #25 sys_clk_i = ~sys_clk_i;
    end
    // ==========================================================
    // tasks
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_i);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic flag_is(input logic f);
        logic [7:0] v;
        rd_reg(ced_pkg::CTRL_ADDR, v);
        chk({7'h00, v[ced_pkg::FLAG_BIT]}, {7'h00, f});
    endtask
    task automatic wait_pulse(input int k);
        for (int n = 0; n < 100; n++) begin
            @(posedge sys_clk_i);
            #1;
            if (ovf[k] === 1'b1) begin
                break;
            end
        end
    endtask
    task automatic print_verdict();
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // watchdog: the sequence needs about 2600 cycles
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fails++;
        print_verdict();
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        foreach (tbl[i]) begin
            if (i < 7) begin
                rd_reg((i == 6) ? 8'h55 : 8'h97 + ((i == 0) ? 8'h00 : 8'(i + 2)), d);
                chk(d, 8'h00);
            end
        end
        @(posedge sys_clk_i);
        #1;
        chk(rdata, 8'h00);
        // select is changed only while the inputs are unlinked
        wr_reg(ced_pkg::CTRL_ADDR, 8'h09);
        #1;
        chk({4'h0, sel, link, on}, 8'h01);
        wr_reg(ced_pkg::CTRL_ADDR, 8'hc9);
        wr_reg(ced_pkg::CTRL_ADDR, 8'he9);
        wr_reg(8'h55, 8'hff);
        rd_reg(ced_pkg::CTRL_ADDR, d);
        chk(d, 8'he9);
        chk({3'h0, sel, link, on, did}, 8'h1f);
        // every mode code, matching and non-matching transitions
        for (int i = 0; i < 12; i++) begin
            e = tbl[i];
            wr_reg(ced_pkg::CTRL_ADDR, 8'he8 | {5'h00, e[5:3]});
            lvl <= e[2];
            repeat (60) @(posedge sys_clk_i);
            wr_reg(ced_pkg::CTRL_ADDR, 8'he8 | {5'h00, e[5:3]});
            lvl <= e[1];
            repeat (60) @(posedge sys_clk_i);
            flag_is(e[0]);
        end
        // flag is sticky and gates the cpu request through bit six
        wr_reg(ced_pkg::CTRL_ADDR, 8'he9);
        lvl <= 1'b0;
        repeat (10) @(posedge sys_clk_i);
        lvl <= 1'b1;
        repeat (10) @(posedge sys_clk_i);
        lvl <= 1'b0;
        repeat (60) @(posedge sys_clk_i);
        flag_is(1'b1);
        wr_reg(ced_pkg::IE_ADDR, 8'h40);
        repeat (2) @(posedge sys_clk_i);
        chk({7'h00, cmp_irq}, 8'h01);
        wr_reg(ced_pkg::IE_ADDR, 8'hbf);
        repeat (2) @(posedge sys_clk_i);
        chk({7'h00, cmp_irq}, 8'h00);
        // disabled comparator: no event, buffers back on
        wr_reg(ced_pkg::CTRL_ADDR, 8'he1);
        lvl <= 1'b1;
        repeat (20) @(posedge sys_clk_i);
        flag_is(1'b0);
        chk({6'h00, on, did}, 8'h00);
        lvl <= 1'b0;
        // debounced rise: flag only after the second timer 1 overflow
        wr_reg(ced_pkg::CTRL_ADDR, 8'heb);
        repeat (60) @(posedge sys_clk_i);
        wait_pulse(1);
        lvl <= 1'b1;
        wait_pulse(1);
        flag_is(1'b0);
        wait_pulse(1);
        repeat (3) @(posedge sys_clk_i);
        flag_is(1'b1);
        // short glitch is discarded and raises the discard event
        lvl <= 1'b0;
        wr_reg(ced_pkg::CTRL_ADDR, 8'heb);
        wr_reg(ced_pkg::IEN_ADDR, 8'h02);
        repeat (60) @(posedge sys_clk_i);
        wr_reg(ced_pkg::ICLR_ADDR, 8'h03);
        wait_pulse(1);
        lvl <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        lvl <= 1'b0;
        repeat (60) @(posedge sys_clk_i);
        flag_is(1'b0);
        wr_reg(ced_pkg::ISTAT_ADDR, 8'h00);
        rd_reg(ced_pkg::ISTAT_ADDR, d);
        chk(d, 8'h02);
        chk({7'h00, irq}, 8'h01);
        wr_reg(ced_pkg::ICLR_ADDR, 8'h02);
        repeat (2) @(posedge sys_clk_i);
        chk({7'h00, irq}, 8'h00);
        // timer sources: an edge needs four agreeing samples
        for (int s = 1; s < 4; s++) begin
            wr_reg(ced_pkg::SRC_ADDR, 8'(s));
            repeat (6) wait_pulse(s - 1);
            wr_reg(ced_pkg::CTRL_ADDR, 8'he9);
            wait_pulse(s - 1);
            lvl <= 1'b1;
            repeat (3) wait_pulse(s - 1);
            flag_is(1'b0);
            wait_pulse(s - 1);
            repeat (3) @(posedge sys_clk_i);
            flag_is(1'b1);
            lvl <= 1'b0;
        end
        rd_reg(ced_pkg::ISTAT_ADDR, d);
        chk(d, 8'h01);
        print_verdict();
    end
endmodule // ced_top_tb_top
`default_nettype wire
